// *** shared/eeprom_link_pkg.sv ***
// Notes on behaviour
// - sample data on clock rise, change after fall
// - data line only pulled low or released
// - falling data with clock high starts transaction
// - rising data with clock high is stop
// - stop after write data launches programming
// - eight bit words, receiver acks ninth clock
// - ack every write word and read select
// - release after read byte, ack sends next
// - no-ack then stop ends read, standby
// - no ack seen: stay released, send nothing
// - select word: type, chip select, read/write
// - respond only on type and strap match
// - last select bit zero writes, one reads
// - unconnected straps and protect read low
// - byte write: select, address, data, all acked
// - ignore clock and data while programming
// - extra data bytes form page write, sixteen
// - low four address bits wrap within page
// - protect high: select, address acked, no write
// - protect high: first data byte not acked
// - protect low allows writes; reads always work
// - programming lasts at most five milliseconds
// - write select not acked while programming
package eeprom_link_pkg;

  // system clock period and the programming time, longest, so rounded down
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PROG_TIME_NS = 5_000_000;
  localparam int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  // cycles lost between the stop on the pins and entering programming
  localparam int unsigned PROG_LATENCY = 4;

  // select word layout
  localparam int unsigned TYPE_MSB = 7;
  localparam int unsigned TYPE_LSB = 4;
  localparam int unsigned CS_MSB = 3;
  localparam int unsigned CS_LSB = 1;
  localparam int unsigned RW_POS = 0;
  // arbitrary type code, not tied to any maker
  localparam logic [3:0] TYPE_CODE_DEF = 4'h5;

  // array and page geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MEM_BYTES = 256;
  localparam int unsigned OFFSET_W = 4;
  localparam int unsigned PAGE_BYTES = 16;

  // bit counter values: last data bit and acknowledge clock
  localparam logic [3:0] LAST_BIT_IDX = 4'h7;
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;

  // synchroniser reset: clock and data idle high, straps and protect low
  localparam logic [5:0] PIN_SYNC_RST = 6'h30;

  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SELECT = 3'b001,
    ST_ADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_PROG = 3'b101
  } link_state_t;

endpackage

// *** shared/scl_capture_if.sv ***
// bits caught on the serial clock, handed to the system clock side
interface scl_capture_if;
  logic [7:0] shift_word; // last eight sampled bits, newest in bit 0
  logic edge_toggle; // flips on every serial clock rise

  modport cap (output shift_word, output edge_toggle);
  modport sys (input shift_word, input edge_toggle);
endinterface

// *** verilog/pin_sync.sv ***
// two flip-flop synchroniser for slow pins into the system clock
module pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_reg; // first stage, read only by the second

  // both stages in one process, second stage feeds the logic
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      meta_reg <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule // pin_sync

// *** verilog/scl_shift_capture.sv ***
// link side: samples data on the serial clock's rising edge
module scl_shift_capture (
  input wire logic i_scl_clk,
  input wire logic i_rst_n,
  input wire logic i_sda_i,
  scl_capture_if.cap cap_p
);
  // the serial clock stops between frames, so reset cannot wait for
  // an edge here: this domain alone clears without a clock
  always_ff @(posedge i_scl_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap_p.shift_word <= 8'h00;
      cap_p.edge_toggle <= 1'b0;
    end else begin
      cap_p.shift_word <= {cap_p.shift_word[6:0], i_sda_i};
      cap_p.edge_toggle <= ~cap_p.edge_toggle; // event for the other side
    end
  end
endmodule // scl_shift_capture

// *** verilog/serial_eeprom_slave_interface.sv ***
// two-wire target with byte array, page buffer and program timer
module serial_eeprom_slave_interface #(
  parameter int unsigned P_PROG_CYCLES = eeprom_link_pkg::PROG_CYCLES,
  parameter logic [3:0] P_TYPE_CODE = eeprom_link_pkg::TYPE_CODE_DEF // arbitrary
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_scl_clk,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [2:0] i_chip_select_straps,
  input wire logic i_write_protect,
  output logic o_prog_busy
);

  localparam int unsigned CNT_W = $clog2(P_PROG_CYCLES + 1);
  // last count of the program timer, trimmed by the pin latency
  localparam logic [CNT_W-1:0] PROG_LAST =
    CNT_W'(P_PROG_CYCLES - eeprom_link_pkg::PROG_LATENCY - 1);

  // link side capture and its hand-over
  scl_capture_if cap_if ();

  scl_shift_capture u_capture (
    .i_scl_clk(i_scl_clk),
    .i_rst_n(i_rst_n),
    .i_sda_i(i_sda_i),
    .cap_p(cap_if.cap)
  );

  // pins into the system clock; clock, data, protect, straps
  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wp_s; // high protects the whole array
  logic [2:0] straps_s;

  pin_sync #(
    .W(6),
    .RST_VAL(eeprom_link_pkg::PIN_SYNC_RST)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_d({i_scl_clk, i_sda_i, i_write_protect, i_chip_select_straps}),
    .o_q(pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  // an open strap or protect pin is pulled low outside and reads low here
  assign wp_s = pins_s[3];
  assign straps_s = pins_s[2:0];

  // protocol state
  eeprom_link_pkg::link_state_t state_reg; // current phase
  logic [3:0] bit_cnt_reg; // bits seen in this word, 8 = ack clock
  logic ack_req_reg; // pull low in the coming ack clock
  logic rw_reg; // read/write bit of the select word
  logic [7:0] addr_reg; // word address, next byte to touch
  logic [7:0] tx_byte_reg; // byte being sent out
  logic [15:0] page_mask_reg; // which buffer slots hold new data
  logic [CNT_W-1:0] prog_cnt_reg; // time spent programming
  logic scl_d_reg; // previous synced clock
  logic sda_d_reg; // previous synced data
  logic tog_s1_reg; // toggle synchroniser, first stage
  logic tog_s2_reg; // toggle synchroniser, second stage
  logic tog_s3_reg; // toggle delayed, for the edge
  logic [7:0] mem [eeprom_link_pkg::MEM_BYTES]; // the array itself
  logic [7:0] page_buf [eeprom_link_pkg::PAGE_BYTES]; // data for one page

  // decoded events
  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic bit_strobe;
  logic take_byte;
  logic take_ack;
  logic sel_match;
  logic prog_done;
  logic [7:0] word;
  logic ack_in;
  logic [3:0] offset;

  assign word = cap_if.shift_word; // steady long after its strobe
  assign ack_in = cap_if.shift_word[0]; // controller's ack, low = more
  assign offset = addr_reg[3:0];

  // clock/data history for edge detection
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // toggle crossing: each serial clock rise becomes one strobe
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else begin
      tog_s1_reg <= cap_if.edge_toggle;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  // event decode; start and stop outrank a strobe in the same cycle
  always_comb begin
    start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    scl_fall = !scl_s && scl_d_reg;
    bit_strobe = tog_s2_reg ^ tog_s3_reg;
    take_byte = bit_strobe && !start_det && !stop_det &&
      bit_cnt_reg == eeprom_link_pkg::LAST_BIT_IDX;
    take_ack = bit_strobe && !start_det && !stop_det &&
      bit_cnt_reg == eeprom_link_pkg::ACK_BIT_IDX;
    // type code then straps, highest strap first
    sel_match = word[eeprom_link_pkg::TYPE_MSB:eeprom_link_pkg::TYPE_LSB] == P_TYPE_CODE &&
      word[eeprom_link_pkg::CS_MSB:eeprom_link_pkg::CS_LSB] == straps_s;
    prog_done = state_reg == eeprom_link_pkg::ST_PROG && prog_cnt_reg == PROG_LAST;
  end

  // protocol sequencing
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg <= eeprom_link_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      ack_req_reg <= 1'b0;
      rw_reg <= 1'b0;
    end else if (state_reg == eeprom_link_pkg::ST_PROG) begin
      // deaf to the bus until done, so polls go unanswered
      if (prog_done) begin
        state_reg <= eeprom_link_pkg::ST_IDLE;
      end
    end else if (start_det) begin
      state_reg <= eeprom_link_pkg::ST_SELECT;
      bit_cnt_reg <= 4'h0;
      ack_req_reg <= 1'b0;
    end else if (stop_det) begin
      // stop after loaded data programs, any other stop is standby
      if (state_reg == eeprom_link_pkg::ST_WDATA && |page_mask_reg) begin
        state_reg <= eeprom_link_pkg::ST_PROG;
      end else begin
        state_reg <= eeprom_link_pkg::ST_IDLE;
      end
      ack_req_reg <= 1'b0;
    end else if (bit_strobe && state_reg != eeprom_link_pkg::ST_IDLE) begin
      if (take_ack) begin
        bit_cnt_reg <= 4'h0;
        ack_req_reg <= 1'b0;
        unique case (state_reg)
          eeprom_link_pkg::ST_SELECT: begin
            state_reg <= rw_reg ? eeprom_link_pkg::ST_RDATA
                                : eeprom_link_pkg::ST_ADDR;
          end
          eeprom_link_pkg::ST_ADDR: begin
            state_reg <= eeprom_link_pkg::ST_WDATA;
          end
          eeprom_link_pkg::ST_WDATA: begin
            state_reg <= eeprom_link_pkg::ST_WDATA;
          end
          eeprom_link_pkg::ST_RDATA: begin
            // high ack: stay released and send nothing more
            state_reg <= ack_in ? eeprom_link_pkg::ST_IDLE
                                : eeprom_link_pkg::ST_RDATA;
          end
          default: begin
            state_reg <= eeprom_link_pkg::ST_IDLE;
          end
        endcase
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (take_byte) begin
          unique case (state_reg)
            eeprom_link_pkg::ST_SELECT: begin
              ack_req_reg <= sel_match;
              rw_reg <= word[eeprom_link_pkg::RW_POS];
              if (!sel_match) begin
                state_reg <= eeprom_link_pkg::ST_IDLE;
              end
            end
            eeprom_link_pkg::ST_ADDR: begin
              ack_req_reg <= 1'b1;
            end
            eeprom_link_pkg::ST_WDATA: begin
              // protected: refuse the data byte and drop the write
              ack_req_reg <= !wp_s;
              if (wp_s) begin
                state_reg <= eeprom_link_pkg::ST_IDLE;
              end
            end
            default: begin
              ack_req_reg <= 1'b0; // read bytes are acked by the controller
            end
          endcase
        end
      end
    end
  end

  // address counter, outgoing byte and buffer occupancy
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      addr_reg <= 8'h00;
      tx_byte_reg <= 8'h00;
      page_mask_reg <= 16'h0000;
    end else if (state_reg == eeprom_link_pkg::ST_PROG) begin
      if (prog_done) begin
        page_mask_reg <= 16'h0000;
      end
    end else if (start_det) begin
      page_mask_reg <= 16'h0000; // a new transaction starts with no data
    end else if (take_byte && state_reg == eeprom_link_pkg::ST_ADDR) begin
      addr_reg <= word;
    end else if (take_byte && state_reg == eeprom_link_pkg::ST_WDATA && !wp_s) begin
      page_mask_reg[offset] <= 1'b1;
      // only the low bits move, so the page wraps on itself
      addr_reg[3:0] <= offset + 4'h1;
    end else if (take_ack && ((state_reg == eeprom_link_pkg::ST_SELECT && rw_reg) ||
                 (state_reg == eeprom_link_pkg::ST_RDATA && !ack_in))) begin
      tx_byte_reg <= mem[addr_reg];
      addr_reg <= addr_reg + 8'h01; // full wrap across the array
    end
  end

  // array and page buffer storage, not reset
  always_ff @(posedge i_clk_sys) begin
    if (take_byte && state_reg == eeprom_link_pkg::ST_WDATA && !wp_s) begin
      page_buf[offset] <= word; // a wrapped byte overwrites its slot
    end
    if (prog_done) begin
      // one commit for the whole page; untouched slots keep old contents
      for (int i = 0; i < eeprom_link_pkg::PAGE_BYTES; i++) begin
        if (page_mask_reg[i]) begin
          mem[{addr_reg[7:4], 4'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // program timer, shortened by the pin latency to stay in budget
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      prog_cnt_reg <= '0;
    end else if (state_reg == eeprom_link_pkg::ST_PROG) begin
      prog_cnt_reg <= prog_cnt_reg + CNT_W'(1);
    end else begin
      prog_cnt_reg <= '0;
    end
  end

  // data pin: only ever pulled low, changed just after the clock falls
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_sda_o <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_sda_o <= 1'b0; // the pull-up makes the high level
      if (state_reg == eeprom_link_pkg::ST_PROG || start_det || stop_det) begin
        o_sda_oe <= 1'b0;
      end else if (scl_fall) begin
        if (state_reg == eeprom_link_pkg::ST_RDATA) begin
          // data bits msb first, released for the controller's ack
          o_sda_oe <= bit_cnt_reg != eeprom_link_pkg::ACK_BIT_IDX &&
            !tx_byte_reg[3'(eeprom_link_pkg::LAST_BIT_IDX - bit_cnt_reg)];
        end else begin
          o_sda_oe <= bit_cnt_reg == eeprom_link_pkg::ACK_BIT_IDX &&
            ack_req_reg;
        end
      end
    end
  end

  // busy flag for the outside
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_prog_busy <= 1'b0;
    end else begin
      o_prog_busy <= state_reg == eeprom_link_pkg::ST_PROG;
    end
  end

  // checks
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_sel_ack_write;
    state_reg == eeprom_link_pkg::ST_SELECT && take_ack && !rw_reg;
  endsequence

  sequence s_sel_ack_read;
    state_reg == eeprom_link_pkg::ST_SELECT && take_ack && rw_reg;
  endsequence

  sequence s_data_taken_open;
    state_reg == eeprom_link_pkg::ST_WDATA && take_byte && !wp_s;
  endsequence

  AST_SDA_NEVER_HIGH: assert property (o_sda_o == 1'b0)
    else $error("data pin driven high");

  AST_OE_AFTER_FALL: assert property ($changed(o_sda_oe) && !o_sda_oe == 1'b0
    |-> $past(scl_fall))
    else $error("data pulled low away from a clock fall");

  AST_START_BEGINS: assert property (start_det && state_reg != eeprom_link_pkg::ST_PROG
    |=> state_reg == eeprom_link_pkg::ST_SELECT && bit_cnt_reg == 4'h0)
    else $error("start not taken");

  AST_MISMATCH_NO_ACK: assert property (state_reg == eeprom_link_pkg::ST_SELECT &&
    take_byte && !sel_match |=> state_reg == eeprom_link_pkg::ST_IDLE && !ack_req_reg)
    else $error("foreign select acknowledged");

  AST_WRITE_TO_ADDR: assert property (s_sel_ack_write
    |=> state_reg == eeprom_link_pkg::ST_ADDR)
    else $error("write select did not go to address");

  AST_READ_TO_DATA: assert property (s_sel_ack_read
    |=> state_reg == eeprom_link_pkg::ST_RDATA ##0 tx_byte_reg == mem[$past(addr_reg)])
    else $error("read select did not load data");

  AST_PAGE_WRAP: assert property (s_data_taken_open |=>
    addr_reg[7:4] == $past(addr_reg[7:4]) &&
    addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1 && ack_req_reg)
    else $error("page offset did not advance in page");

  AST_WP_NACK: assert property (state_reg == eeprom_link_pkg::ST_WDATA && take_byte && wp_s
    |=> state_reg == eeprom_link_pkg::ST_IDLE && !ack_req_reg &&
    page_mask_reg == $past(page_mask_reg))
    else $error("protected data byte accepted");

  AST_STOP_PROGRAMS: assert property (state_reg == eeprom_link_pkg::ST_WDATA && stop_det &&
    |page_mask_reg |=> state_reg == eeprom_link_pkg::ST_PROG ##1 o_prog_busy)
    else $error("stop after data did not program");

  AST_PROG_DEAF: assert property (state_reg == eeprom_link_pkg::ST_PROG && !prog_done
    |=> state_reg == eeprom_link_pkg::ST_PROG && !o_sda_oe)
    else $error("bus answered while programming");

  AST_PROG_BOUND: assert property (state_reg == eeprom_link_pkg::ST_PROG
    |-> prog_cnt_reg <= PROG_LAST)
    else $error("programming ran too long");

  AST_READ_NACK_ENDS: assert property (state_reg == eeprom_link_pkg::ST_RDATA && take_ack &&
    ack_in |=> state_reg == eeprom_link_pkg::ST_IDLE ##1 !o_sda_oe)
    else $error("read went on after no-ack");

endmodule // serial_eeprom_slave_interface

// *** verification/bus_controller_model.sv ***
// bus controller stand-in: drives the serial clock, pulls data low or releases it
module bus_controller_model (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle: clock parked high, data left to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // odd offset keeps the serial clock off the system clock's phase
  task automatic start_cond();
    #3.3 o_sda_low = 1'b0;
    #40 o_scl = 1'b1;
    #80 o_sda_low = 1'b1; // data falls while clock high
    #80 o_scl = 1'b0;
  endtask

  // clock stands still high after the stop, outside any frame
  task automatic stop_cond();
    #40 o_sda_low = 1'b1;
    #40 o_scl = 1'b1;
    #80 o_sda_low = 1'b0; // data rises while clock high
    #80;
  endtask

  // one clock: data set mid-low, wire sampled mid-high
  task automatic clock_bit(input logic drive_low, output logic seen);
    #40 o_sda_low = drive_low; // data moves only with the clock low
    #40 o_scl = 1'b1;
    #40 seen = i_sda;
    #40 o_scl = 1'b0;
  endtask

  // select, address or data word, msb first, then release for the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(~b[i], s); // eight bits per word
    end
    clock_bit(1'b0, s); // transmitter releases on the ninth clock
    ack = (s === 1'b0);
  endtask

  // read word; ack_low pulls low on the ninth clock to ask for more
  task automatic recv_byte(output logic [7:0] b, input logic ack_low);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b0, s);
      b[i] = s;
    end
    clock_bit(ack_low, s); // receiver answers on the ninth clock
  endtask
endmodule // bus_controller_model

// *** verification/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PROG = 1024; // shortened, still longer than one poll
  localparam int LIMIT = 60000; // cycle ceiling, a little over twice the plan
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] straps = 3'h0;
  logic wp = 1'b0;
  logic scl, ctl_low, dev_o, dev_oe, busy, sda;
  logic [31:0] seed = 32'h2c9dc60b;
  logic [7:0] exp_mem [256]; // expected array, updated as writes are sent
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 clk_sys = ~clk_sys;
  // open-drain wire with pull-up: low if anyone pulls
  assign sda = ~(ctl_low | (dev_oe & ~dev_o));

  serial_eeprom_slave_interface #(.P_PROG_CYCLES(PROG)) i_serial_eeprom_slave_interface (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_scl_clk(scl), .i_sda_i(sda),
    .o_sda_o(dev_o), .o_sda_oe(dev_oe), .i_chip_select_straps(straps),
    .i_write_protect(wp), .o_prog_busy(busy));
  bus_controller_model i_bus_controller_model (.i_sda(sda), .o_scl(scl), .o_sda_low(ctl_low));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] rnd8();
    seed = lfsr_next(seed);
    return seed[7:0];
  endfunction
  // select word for this device
  function automatic logic [7:0] sel(input logic rw);
    return {eeprom_link_pkg::TYPE_CODE_DEF, straps, rw};
  endfunction

  task automatic st();
    i_bus_controller_model.start_cond();
  endtask
  task automatic sp();
    i_bus_controller_model.stop_cond();
  endtask
  task automatic tx(input logic [7:0] b, output logic a);
    i_bus_controller_model.send_byte(b, a);
  endtask
  task automatic rx(output logic [7:0] b, input logic lo);
    i_bus_controller_model.recv_byte(b, lo);
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // wire watch and hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (rst_n && dev_oe === 1'b1 && dev_o !== 1'b0) begin
      failures++;
      $display("ERROR sda_level expected 0 seen %b", dev_o);
    end
    if (cyc == LIMIT) begin
      failures++;
      $display("ERROR timeout expected done seen running");
      give_verdict();
    end
  end

  task automatic wait_busy_low(output int n);
    n = 0;
    while (busy !== 1'b0 && n < PROG + 16) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  // write n random bytes; ok says whether data is accepted
  task automatic do_write(input logic [7:0] addr, input int n, input logic ok);
    logic a;
    logic [7:0] d;
    int w;
    st();
    tx(sel(1'b0), a);
    check("sel_ack", 8'h01, {7'h0, a});
    tx(addr, a);
    check("addr_ack", 8'h01, {7'h0, a});
    for (int k = 0; k < n; k++) begin
      d = rnd8();
      tx(d, a);
      check("data_ack", {7'h0, ok}, {7'h0, a});
      if (ok)
        exp_mem[{addr[7:4], addr[3:0] + k[3:0]}] = d;
    end
    sp();
    repeat (10) @(posedge clk_sys);
    check("busy", {7'h0, ok}, {7'h0, busy});
    if (ok) begin
      st();
      tx(sel(1'b0), a);
      check("poll_busy", 8'h00, {7'h0, a});
      sp();
      wait_busy_low(w);
      check("prog_end", 8'h00, {7'h0, busy});
      st();
      tx(sel(1'b0), a);
      check("poll_done", 8'h01, {7'h0, a});
      sp();
    end
  endtask

  // dummy write, repeated start, sequential read of n bytes
  task automatic do_read(input logic [7:0] addr, input int n);
    logic a;
    logic [7:0] d;
    st();
    tx(sel(1'b0), a);
    tx(addr, a);
    st();
    tx(sel(1'b1), a);
    check("rsel_ack", 8'h01, {7'h0, a});
    for (int k = 0; k < n; k++) begin
      rx(d, k < n - 1);
      check("rdata", exp_mem[8'(addr + k)], d);
    end
    sp();
  endtask

  initial begin
    logic a;
    logic [7:0] d;
    logic [7:0] adr;
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    // random byte writes under random strap settings
    for (int r = 0; r < 3; r++) begin
      @(posedge clk_sys);
      d = rnd8();
      #1 straps = d[2:0];
      repeat (4) @(posedge clk_sys);
      adr = rnd8();
      do_write(adr, 1, 1'b1);
      do_read(adr, 1);
      $display("test byte_write round %0d done", r);
    end
    // full page plus one wraps over offset 0, then a short wrap must spare the rest
    d = rnd8();
    adr = {d[7:4], 4'h0};
    do_write(adr, 17, 1'b1);
    do_write(adr | 8'h0f, 2, 1'b1);
    do_read(adr, 16);
    $display("test page_write done");
    // read address rolls from the top of the array to zero
    do_write(8'hff, 1, 1'b1);
    do_write(8'h00, 1, 1'b1);
    do_read(8'hff, 2);
    $display("test read_wrap done");
    // protect: data refused, nothing programmed, reads still served
    @(posedge clk_sys);
    #1 wp = 1'b1;
    repeat (4) @(posedge clk_sys);
    do_write(8'h00, 1, 1'b0);
    do_read(8'h00, 1);
    // leaves the read address on 00, a written byte, for the no-ack test
    do_read(8'hff, 1);
    @(posedge clk_sys);
    #1 wp = 1'b0;
    $display("test write_protect done");
    // foreign selects: one strap bit flipped, or a wrong type code
    for (int i = 0; i < 4; i++) begin
      d = (i == 3) ? {~eeprom_link_pkg::TYPE_CODE_DEF, straps, 1'b1}
                   : {eeprom_link_pkg::TYPE_CODE_DEF, straps ^ (3'h1 << i), 1'b0};
      st();
      tx(d, a);
      check("foreign_ack", 8'h00, {7'h0, a});
      sp();
    end
    $display("test foreign_select done");
    // no ack and no stop: device must leave the wire to the pull-up
    st();
    tx(sel(1'b1), a);
    rx(d, 1'b0);
    rx(d, 1'b0);
    check("released", 8'hff, d);
    sp();
    $display("test read_no_ack done");
    give_verdict();
  end
endmodule // tb_top
